// ===== core/amss_phase_counter.sv
`timescale 1ns/1ps
// Down counter timing one phase; done when the count reaches one
module amss_phase_counter #(
    parameter int WIDTH = 13
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic load,
    input wire logic [WIDTH-1:0] loadValue,
    output logic done
);
    logic [WIDTH-1:0] count;
    // A load value of zero is treated as one period
    assign done = (count <= {{(WIDTH-1){1'b0}}, 1'b1});

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            count <= '0;
        end else if (load) begin
            count <= loadValue;
        end else if (!done) begin
            count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end
endmodule // amss_phase_counter

// ===== core/amss_pkg.sv
package amss_pkg;
    localparam int CLOCK_MHZ = 125;
    localparam int CYCLES_PER_WAIT = 16;
    localparam int WAIT_RELEASE_CYCLES = 4;
    localparam int WAIT_SYNC_STAGES = 2;
    localparam int WAIT_COUNT_MAX = 256;
    localparam int ADDR_WIDTH = 21;
    localparam int PAGE_WIDTH = 2;
    localparam int DATA_WIDTH = 16;
    localparam int SELECT_WIDTH = 4;
    localparam int FIELD_WIDTH = 8;
    localparam int WAIT_FIELD_WIDTH = 9;
    typedef enum logic [2:0] {
        AMSS_IDLE = 3'b000,
        AMSS_SETUP = 3'b001,
        AMSS_STROBE = 3'b010,
        AMSS_RELEASE = 3'b011,
        AMSS_HOLD = 3'b100,
        AMSS_TURN = 3'b101
    } amss_state_t;
endpackage

// ===== core/async_memory_strobe_sequencer.sv
`timescale 1ns/1ps
module async_memory_strobe_sequencer #(
    parameter int SELECT_WIDTH = amss_pkg::SELECT_WIDTH
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic reqValid,
    input wire logic reqWrite,
    input wire logic [amss_pkg::ADDR_WIDTH-1:0] reqAddr,
    input wire logic [amss_pkg::PAGE_WIDTH-1:0] reqPage,
    input wire logic [amss_pkg::DATA_WIDTH-1:0] reqWriteData,
    input wire logic [SELECT_WIDTH-1:0] reqSelect,
    input wire logic [amss_pkg::FIELD_WIDTH-1:0] read_setup_cycles,
    input wire logic [amss_pkg::FIELD_WIDTH-1:0] read_strobe_cycles,
    input wire logic [amss_pkg::FIELD_WIDTH-1:0] read_hold_cycles,
    input wire logic [amss_pkg::FIELD_WIDTH-1:0] write_setup_cycles,
    input wire logic [amss_pkg::FIELD_WIDTH-1:0] write_strobe_cycles,
    input wire logic [amss_pkg::FIELD_WIDTH-1:0] write_hold_cycles,
    input wire logic [amss_pkg::FIELD_WIDTH-1:0] turnaround_cycles,
    input wire logic [amss_pkg::WAIT_FIELD_WIDTH-1:0] max_wait_limit,
    input wire logic extended_wait_en,
    input wire logic select_strobe_en,
    input wire logic wait_in,
    input wire logic timeoutClear,
    input wire logic [amss_pkg::DATA_WIDTH-1:0] data_in,
    output logic reqReady,
    output logic respValid,
    output logic [amss_pkg::DATA_WIDTH-1:0] respReadData,
    output logic [amss_pkg::WAIT_FIELD_WIDTH-1:0] ext_wait_count,
    output logic timeoutFlag,
    output logic read_strobe_n,
    output logic write_strobe_n,
    output logic [SELECT_WIDTH-1:0] chip_select_n,
    output logic [amss_pkg::PAGE_WIDTH-1:0] page_select_bits,
    output logic [amss_pkg::ADDR_WIDTH-1:0] addr_bus,
    output logic [amss_pkg::DATA_WIDTH-1:0] data_out,
    output logic data_oe_n
);
    localparam int CW = 13;
    localparam logic [CW-1:0] RELEASE_LOAD =
        CW'(amss_pkg::WAIT_RELEASE_CYCLES);
    localparam logic [4:0] WAIT_UNIT = 5'(amss_pkg::CYCLES_PER_WAIT);

    initial begin
        if (SELECT_WIDTH < 1 || SELECT_WIDTH > 8) begin
            $error("SELECT_WIDTH out of range");
        end
    end

    function automatic logic [CW-1:0] widen(
        input logic [amss_pkg::FIELD_WIDTH-1:0] v);
        widen = {{(CW-amss_pkg::FIELD_WIDTH){1'b0}}, v};
    endfunction

    amss_pkg::amss_state_t state;
    amss_pkg::amss_state_t next_state;
    logic isWrite;
    logic [SELECT_WIDTH-1:0] selectHeld;
    logic [1:0] waitSync;
    logic waitLive;
    logic [4:0] unitCount;
    logic load;
    logic [CW-1:0] loadValue;
    logic phaseDone;
    logic waitEnded;

    // Two-stage synchroniser; only the second stage is read
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            waitSync <= 2'b00;
        end else begin
            waitSync <= {waitSync[0], wait_in};
        end
    end
    assign waitLive = waitSync[1] && extended_wait_en;

    // Phase selection, each length straight from its software field
    wire [CW-1:0] setupLen = widen(isWrite ? write_setup_cycles
                                           : read_setup_cycles);
    wire [CW-1:0] strobeLen = widen(isWrite ? write_strobe_cycles
                                            : read_strobe_cycles);
    wire [CW-1:0] holdLen = widen(isWrite ? write_hold_cycles
                                          : read_hold_cycles);
    wire [CW-1:0] turnLen = widen(turnaround_cycles);
    wire startReq = (state == amss_pkg::AMSS_IDLE) && reqValid;
    wire unitWrap = (unitCount == WAIT_UNIT - 5'd1);
    wire overLimit = (ext_wait_count >= max_wait_limit);
    // Wait live at the strobe end stretches it per cycle, counted in 16-period units
    wire stretching = waitLive && !overLimit;
    // Release leaves a 4 period tail before strobe rises
    wire strobeEnd = phaseDone && !stretching;

    amss_phase_counter #(
        .WIDTH(CW)
    ) u_phase (
        .clock(clock),
        .reset(reset),
        .load(load),
        .loadValue(loadValue),
        .done(phaseDone)
    );

    // Next state and the length loaded for the next phase
    always_comb begin
        next_state = state;
        load = 1'b0;
        loadValue = '0;
        unique case (state)
            amss_pkg::AMSS_IDLE: begin
                if (reqValid) begin
                    next_state = amss_pkg::AMSS_SETUP;
                    load = 1'b1;
                    loadValue = widen(reqWrite ? write_setup_cycles
                                               : read_setup_cycles);
                end
            end
            amss_pkg::AMSS_SETUP: begin
                if (phaseDone) begin
                    next_state = amss_pkg::AMSS_STROBE;
                    load = 1'b1;
                    loadValue = strobeLen;
                end
            end
            amss_pkg::AMSS_STROBE: begin
                if (strobeEnd && waitEnded) begin
                    next_state = amss_pkg::AMSS_RELEASE;
                    load = 1'b1;
                    loadValue = RELEASE_LOAD;
                end else if (strobeEnd) begin
                    next_state = amss_pkg::AMSS_HOLD;
                    load = 1'b1;
                    loadValue = holdLen;
                end
            end
            amss_pkg::AMSS_RELEASE: begin
                if (phaseDone) begin
                    next_state = amss_pkg::AMSS_HOLD;
                    load = 1'b1;
                    loadValue = holdLen;
                end
            end
            amss_pkg::AMSS_HOLD: begin
                if (phaseDone) begin
                    next_state = amss_pkg::AMSS_TURN;
                    load = 1'b1;
                    loadValue = turnLen;
                end
            end
            amss_pkg::AMSS_TURN: begin
                if (phaseDone) begin
                    next_state = amss_pkg::AMSS_IDLE;
                end
            end
            default: begin
                next_state = amss_pkg::AMSS_IDLE;
            end
        endcase
    end

    wire inAccess = (state == amss_pkg::AMSS_SETUP) ||
                    (state == amss_pkg::AMSS_STROBE) ||
                    (state == amss_pkg::AMSS_RELEASE) ||
                    (state == amss_pkg::AMSS_HOLD);
    wire nextStrobe = (next_state == amss_pkg::AMSS_STROBE) ||
                      (next_state == amss_pkg::AMSS_RELEASE);
    wire nextAccess = (next_state == amss_pkg::AMSS_SETUP) || nextStrobe ||
                      (next_state == amss_pkg::AMSS_HOLD);
    // Strobe mode keys the select to the strobe phase itself
    wire nextSelect = select_strobe_en ? nextStrobe : nextAccess;
    wire readEnding = (state == amss_pkg::AMSS_HOLD) && phaseDone && !isWrite;
    wire timeoutHit = (state == amss_pkg::AMSS_STROBE) && waitLive &&
                      overLimit && phaseDone;

    // State, latched request and wait-cycle bookkeeping
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state <= amss_pkg::AMSS_IDLE;
            isWrite <= 1'b0;
            selectHeld <= '0;
            unitCount <= 5'd0;
            ext_wait_count <= '0;
            waitEnded <= 1'b0;
        end else begin
            state <= next_state;
            if (startReq) begin
                isWrite <= reqWrite;
                selectHeld <= reqSelect;
                ext_wait_count <= '0;
                unitCount <= 5'd0;
                waitEnded <= 1'b0;
            end else if (state == amss_pkg::AMSS_STROBE && stretching &&
                         phaseDone) begin
                unitCount <= unitWrap ? 5'd0 : unitCount + 5'd1;
                waitEnded <= 1'b1;
                // Each started unit counts as one wait cycle
                if (unitCount == 5'd0) begin
                    ext_wait_count <= ext_wait_count + 9'd1;
                end
            end
        end
    end

    // Memory pins; address and page span setup through hold
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            read_strobe_n <= 1'b1;
            write_strobe_n <= 1'b1;
            chip_select_n <= '1;
            addr_bus <= '0;
            page_select_bits <= '0;
            data_out <= '0;
            data_oe_n <= 1'b1;
        end else begin
            read_strobe_n <= !(nextStrobe && !(startReq ? reqWrite
                                                        : isWrite));
            write_strobe_n <= !(nextStrobe && isWrite);
            chip_select_n <= nextSelect ? ~(startReq ? reqSelect
                                                     : selectHeld) : '1;
            if (startReq) begin
                addr_bus <= reqAddr;
                page_select_bits <= reqPage;
                data_out <= reqWriteData;
            end
            data_oe_n <= !(nextAccess && (startReq ? reqWrite
                                                   : isWrite));
        end
    end

    // Handshake, read capture and sticky timeout; set beats clear
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            reqReady <= 1'b0;
            respValid <= 1'b0;
            respReadData <= '0;
            timeoutFlag <= 1'b0;
        end else begin
            reqReady <= (next_state == amss_pkg::AMSS_IDLE) && !startReq;
            respValid <= (state == amss_pkg::AMSS_HOLD) && phaseDone;
            if (state == amss_pkg::AMSS_STROBE && strobeEnd && !isWrite) begin
                respReadData <= data_in;
            end
            if (timeoutHit) begin
                timeoutFlag <= 1'b1;
            end else if (timeoutClear) begin
                timeoutFlag <= 1'b0;
            end
        end
    end

    wire unusedRead = readEnding | inAccess;
endmodule // async_memory_strobe_sequencer

// ===== testbench/amss_memory_model.sv
`timescale 1ns/1ps
// Static memory whose wait line is held waitLen cycles per strobe
module amss_memory_model (
    input wire logic clock,
    input wire logic [3:0] chip_select_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic [20:0] addr_bus,
    input wire logic [15:0] data_out,
    input wire logic data_oe_n,
    input wire logic [7:0] waitLen,
    output logic [15:0] data_in,
    output logic wait_in
);
    logic [15:0] mem [16];
    logic [15:0] lastData = 16'h0000;
    logic [7:0] waitLeft = 8'h00;
    logic strobeWas = 1'b1;
    wire strobeIdle = read_strobe_n & write_strobe_n;
    wire hit = !(&chip_select_n);
    // Undriven bus toggles so a stale word can never hold for two cycles in a row
    assign data_in = (hit && !read_strobe_n) ? mem[addr_bus[3:0]] : ~lastData;
    assign wait_in = (waitLeft != 8'h00);
    // Wait rises one cycle into the strobe, well ahead of its end
    always @(posedge clock) begin
        lastData <= data_in;
        strobeWas <= strobeIdle;
        if (hit && !write_strobe_n && !data_oe_n)
            mem[addr_bus[3:0]] <= data_out;
        if (strobeWas && !strobeIdle && waitLen != 8'h00)
            waitLeft <= waitLen;
        else if (waitLeft != 8'h00)
            waitLeft <= waitLeft - 8'h01;
    end
endmodule // amss_memory_model

// ===== testbench/amss_monitor.sv
`timescale 1ns/1ps
// Pin-side timing checks on the sequencer
module amss_monitor #(
    parameter int SELECT_WIDTH = 4
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic reqReady,
    input wire logic respValid,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic [SELECT_WIDTH-1:0] chip_select_n,
    input wire logic [20:0] addr_bus,
    input wire logic [1:0] page_select_bits,
    input wire logic [15:0] data_out,
    input wire logic data_oe_n,
    input wire logic wait_in,
    input wire logic [8:0] ext_wait_count,
    input wire logic [8:0] max_wait_limit,
    input wire logic extended_wait_en,
    input wire logic select_strobe_en,
    input wire logic [7:0] read_strobe_cycles
);
    logic [15:0] lowCnt;
    wire strobeIdle = read_strobe_n & write_strobe_n;
    wire [15:0] wantLen = (read_strobe_cycles == 8'h00) ? 16'h0001 :
        {8'h00, read_strobe_cycles};
    // Strobe pulse length so far; zero count acts as one
    always_ff @(posedge clock or posedge reset) begin
        if (reset)
            lowCnt <= 16'h0000;
        else
            lowCnt <= strobeIdle ? 16'h0000 : lowCnt + 16'h0001;
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    AST_STROBE_WIDTH: assert property ($rose(read_strobe_n)
        && !extended_wait_en |-> lowCnt == wantLen) else $error("width");
    AST_SELECT_SETUP: assert property (!select_strobe_en
        && $fell(strobeIdle) |-> !(&$past(chip_select_n))) else $error("cs");
    AST_SELECT_TOGETHER: assert property (select_strobe_en
        && $fell(strobeIdle) |-> &$past(chip_select_n) && !(&chip_select_n))
        else $error("cs strobe");
    AST_ADDR_STABLE: assert property (!strobeIdle |-> $stable(addr_bus)
        && $stable(page_select_bits)) else $error("address moved");
    AST_WAIT_RELEASE: assert property ($fell(wait_in) && !read_strobe_n
        |-> ##[1:24] read_strobe_n) else $error("release");
    AST_DATA_DRIVEN: assert property (!write_strobe_n
        |-> !data_oe_n && $stable(data_out)) else $error("write data");
    AST_WAIT_BOUND: assert property (respValid
        |-> ext_wait_count <= max_wait_limit) else $error("wait count");
    AST_IDLE_QUIET: assert property (reqReady
        |-> strobeIdle && &chip_select_n && data_oe_n) else $error("idle");
endmodule // amss_monitor
bind async_memory_strobe_sequencer amss_monitor #(
    .SELECT_WIDTH(SELECT_WIDTH)) mon (.*);

// ===== testbench/tb.sv
`timescale 1ns/1ps
// Single accesses timed and checked at the memory pins
module tb;
    logic clock, reset, reqValid, reqWrite, timeoutClear, timeoutFlag;
    logic extended_wait_en, select_strobe_en, wait_in, reqReady, respValid;
    logic read_strobe_n, write_strobe_n, data_oe_n;
    logic [20:0] reqAddr, addr_bus;
    logic [1:0] reqPage, page_select_bits;
    logic [15:0] reqWriteData, data_in, respReadData, data_out;
    logic [3:0] reqSelect, chip_select_n;
    logic [7:0] read_setup_cycles, read_strobe_cycles, read_hold_cycles;
    logic [7:0] write_setup_cycles, write_strobe_cycles, write_hold_cycles;
    logic [7:0] turnaround_cycles, waitLen;
    logic [8:0] max_wait_limit, ext_wait_count;
    int num_errors, checked, selLow, stbLow, gap, g1;
    async_memory_strobe_sequencer uut (.*);
    amss_memory_model mem (.*);
    // 125 MHz core clock
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] want);
        checked++;
        if (seen !== want) begin
            num_errors++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, want, seen);
        end
    endtask
    // One access: counts select-low and strobe-low cycles, then idle gap
    task automatic acc(input logic wr, input logic [20:0] a,
        input logic [15:0] d);
        int n;
        for (n = 0; n < 900 && reqReady !== 1'b1; n++) @(negedge clock);
        {reqValid, reqWrite, reqAddr, reqPage, reqWriteData} = {1'b1, wr, a,
            a[1:0], d};
        @(negedge clock);
        reqValid = 1'b0;
        selLow = 0;
        stbLow = 0;
        for (n = 0; n < 9000 && respValid !== 1'b1; n++) begin
            selLow += (chip_select_n !== 4'hF);
            stbLow += ((read_strobe_n & write_strobe_n) !== 1'b1);
            @(negedge clock);
        end
        for (gap = 0; gap < 900 && reqReady !== 1'b1; gap++) @(negedge clock);
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // A hang is anything far past the few hundred cycles expected
    initial begin
        #200000;
        num_errors++;
        $display("watchdog expired");
        test_done;
    end
    initial begin
        {reset, reqValid, reqWrite, timeoutClear} = 4'h8;
        {extended_wait_en, select_strobe_en, reqSelect} = 6'h02;
        {reqAddr, reqPage, reqWriteData} = 39'h00_0000_0000;
        {read_setup_cycles, read_strobe_cycles, read_hold_cycles} = 24'h02_0803;
        {write_setup_cycles, write_strobe_cycles, write_hold_cycles} = 24'h03_0602;
        turnaround_cycles = 8'h02;
        waitLen = 8'h00;
        max_wait_limit = 9'h008;
        num_errors = 0;
        checked = 0;
        repeat (3) @(posedge clock);
        @(negedge clock);
        reset = 1'b0;
        @(negedge clock);
        check("ready", reqReady, 1);
        // Write then read back; widths follow the programmed counts
        acc(1'b1, 21'h0_0005, 16'hA5C3);
        check("wlow", stbLow, 6);
        check("wsel", selLow, 11);
        check("waddr", addr_bus, 5);
        acc(1'b0, 21'h0_0005, 16'h0000);
        check("rdata", respReadData, 16'hA5C3);
        check("rsel", selLow, 13);
        check("rpage", page_select_bits, 1);
        $display("test readwrite done");
        // Strobe count sweep, zero acting as one
        for (int i = 0; i < 4; i++) begin
            read_strobe_cycles = i[7:0];
            acc(1'b0, 21'h0_0005, 16'h0000);
            check("rlow", stbLow, (i == 0) ? 1 : i);
        end
        g1 = gap;
        check("turn0", g1, 2);
        turnaround_cycles = 8'h05;
        acc(1'b0, 21'h0_0005, 16'h0000);
        check("turn", gap, 5);
        select_strobe_en = 1'b1;
        acc(1'b1, 21'h0_0009, 16'h3C5A);
        check("ssel", selLow, 6);
        select_strobe_en = 1'b0;
        $display("test counts done");
        // Wait held past the strobe end adds one extension unit
        read_strobe_cycles = 8'h08;
        extended_wait_en = 1'b1;
        waitLen = 8'h0C;
        acc(1'b0, 21'h0_0009, 16'h0000);
        check("waits", ext_wait_count, 1);
        check("stretch", stbLow > 8, 1);
        check("esel", selLow - stbLow, 5);
        check("edata", respReadData, 16'h3C5A);
        // Wait outlasting the limit ends the access with the flag set
        {max_wait_limit, waitLen} = 17'h0_013C;
        acc(1'b0, 21'h0_0009, 16'h0000);
        check("tflag", timeoutFlag, 1);
        check("tcount", ext_wait_count, 1);
        timeoutClear = 1'b1;
        @(negedge clock);
        timeoutClear = 1'b0;
        check("tclear", timeoutFlag, 0);
        $display("test wait done");
        test_done;
    end
endmodule // tb
